/* rtl/stop_wake_ctrl.sv */
/*
 * stop-recovery select, watchdog configuration and timers, with an
 * avalon-mm slave and a level interrupt.
 * assumes one 100 MHz clock, async active-low reset, pins synchronous.
 */
// The Avalon-MM register port was left to the implementer.
`include "stop_wake_map.svh"
`timescale 1ns/10ps
`default_nettype none
module stop_wake_ctrl #(
    parameter int WD_CYC0   = `SWS_WD_CYC(`SWS_WD_MS0),
    parameter int WD_CYC1   = `SWS_WD_CYC(`SWS_WD_MS1),
    parameter int WD_CYC2   = `SWS_WD_CYC(`SWS_WD_MS2),
    parameter int WD_CYC3   = `SWS_WD_CYC(`SWS_WD_MS3),
    parameter int RST_CLOCKS = `SWS_RST_CLOCKS
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // avalon-mm slave
    input  wire logic [5:0]                address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    output logic [31:0]                    readdata,
    output logic                           waitrequest,
    // core power state requests
    input  wire logic                      stop_req,
    input  wire logic                      halt_req,
    input  wire logic                      halt_exit,
    // wake pins and directions
    input  wire stop_wake_pkg::wake_pins_t pins,
    input  wire stop_wake_pkg::wake_pins_t is_out,
    input  wire logic                      first_wake_in,
    // timer clears
    input  wire logic                      timer_clear_input_a,
    input  wire logic                      timer_clear_input_b,
    // status out
    output logic                           stopped,
    output logic                           stop_recover,
    output logic                           watchdog_reset,
    output logic                           reset_timer_done,
    output logic                           irq
);
    import stop_wake_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    initial begin
        if (WD_CYC0 < 1 || WD_CYC0 > WD_CYC1 || WD_CYC1 > WD_CYC2 || WD_CYC2 > WD_CYC3 ||
            RST_CLOCKS < 1 || RST_CLOCKS > 255)
            $error("stop_wake_ctrl: bad timing parameters");
    end

    typedef struct packed {
        logic [7:0]  second;      // source and level fields
        logic [7:0]  first;       // first wake select, bit 0 enables first_wake_in
        logic [7:0]  wdog;        // watchdog mode
        logic [2:0]  sts;         // 0 wake, 1 watchdog, 2 reset timer
        logic [2:0]  msk;
        run_state_t  st;
        logic [31:0] wd_cnt;
        logic        wd_run;
        logic [7:0]  rc_cnt;
        logic        rc_run;
        logic        clr_a;
        logic        clr_b;
        logic        ack;
        logic [31:0] rdata;
        logic        recov;
        logic        wd_rst;
        logic        rc_done;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic        wake2;
    logic        wake_any;
    logic [31:0] wd_limit;
    logic [3:0]  idx;

    // ****************************************************************
    // wake combination
    // ****************************************************************
    wake_combiner u_comb (
        .src    (wake_src_t'(s_q.second[`SWS_SRC_MSB:`SWS_SRC_LSB])), // RULE1
        .level  (s_q.second[`SWS_LVL_BIT]),                          // RULE1
        .pins   (pins),
        .is_out (is_out),
        .wake   (wake2)
    );

    // either register's event ends stop
    assign wake_any = wake2 | (s_q.first[0] & first_wake_in);        // RULE7

    // timeout per select code
    always_comb begin
        case (s_q.wdog[1:0])
            2'b00:   wd_limit = WD_CYC0;                             // RULE10
            2'b01:   wd_limit = WD_CYC1;                             // RULE10
            2'b10:   wd_limit = WD_CYC2;                             // RULE10
            default: wd_limit = WD_CYC3;                             // RULE10
        endcase
    end

    assign idx = address[5:2];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d         = s_q;
        s_d.ack     = 1'b0;
        s_d.recov   = 1'b0;
        s_d.wd_rst  = 1'b0;
        s_d.rc_done = 1'b0;
        s_d.clr_a   = timer_clear_input_a;
        s_d.clr_b   = timer_clear_input_b;

        // power state: stop left on the first cycle a wake is seen
        case (s_q.st)
            ST_RUN: begin
                if (stop_req)
                    s_d.st = ST_STOP;
                else if (halt_req)
                    s_d.st = ST_HALT;
            end
            ST_STOP: begin
                if (wake_any) begin                                  // RULE13
                    s_d.st    = ST_RUN;
                    s_d.recov = 1'b1;
                end
            end
            ST_HALT: begin
                if (halt_exit)
                    s_d.st = ST_RUN;
            end
            default: s_d.st = ST_RUN;
        endcase

        // watchdog: started by clear a, paused in stop, and in halt unless enabled
        if (timer_clear_input_a && !s_q.clr_a) begin                 // RULE12
            s_d.wd_run = 1'b1;
            s_d.wd_cnt = 32'h0000_0000;
        end else if (s_q.wd_run && s_q.st != ST_STOP &&
                     (s_q.st != ST_HALT || s_q.wdog[`SWS_WD_HALT_BIT])) begin // RULE11
            if (s_q.wd_cnt + 32'h0000_0001 >= wd_limit) begin
                s_d.wd_cnt = 32'h0000_0000;
                s_d.wd_rst = 1'b1;
            end else begin
                s_d.wd_cnt = s_q.wd_cnt + 32'h0000_0001;
            end
        end

        // reset timer: counts RST_CLOCKS after clear b rises
        if (timer_clear_input_b && !s_q.clr_b) begin                 // RULE12
            s_d.rc_run = 1'b1;
            s_d.rc_cnt = 8'h00;
        end else if (s_q.rc_run) begin
            if (s_q.rc_cnt == 8'(RST_CLOCKS - 1)) begin
                s_d.rc_run  = 1'b0;
                s_d.rc_done = 1'b1;
            end else begin
                s_d.rc_cnt = s_q.rc_cnt + 8'h01;
            end
        end

        // bus: one wait cycle, answer on the second
        if ((read || write) && !s_q.ack) begin
            s_d.ack   = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (write) begin
                case (idx)
                    // reserved bits are kept zero whatever software writes
                    `SWS_IDX_SECOND: s_d.second = writedata[7:0] & 8'h5c; // RULE9
                    `SWS_IDX_FIRST:  s_d.first  = writedata[7:0];
                    `SWS_IDX_WDOG:   s_d.wdog   = {5'h00, writedata[2:0]};
                    `SWS_IDX_MASK:   s_d.msk    = writedata[2:0];
                    default: ;
                endcase
            end else begin
                case (idx)
                    `SWS_IDX_SECOND: s_d.rdata = 32'h0000_0000;      // RULE1
                    `SWS_IDX_FIRST:  s_d.rdata = {24'h00_0000, s_q.first};
                    `SWS_IDX_WDOG:   s_d.rdata = {24'h00_0000, s_q.wdog};
                    `SWS_IDX_MASK:   s_d.rdata = {29'h0000_0000, s_q.msk};
                    `SWS_IDX_STATUS: begin
                        s_d.rdata = {27'h000_0000, s_q.st, s_q.sts};
                        s_d.sts   = 3'b000;                          // read clears
                    end
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // events set sticky bits after any clear, so a set wins
        if (s_d.recov)
            s_d.sts[0] = 1'b1;
        if (s_d.wd_rst)
            s_d.sts[1] = 1'b1;
        if (s_d.rc_done)
            s_d.sts[2] = 1'b1;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.second <= `SWS_SECOND_RST;                           // RULE2
            s_q.first  <= `SWS_FIRST_RST;
            s_q.wdog   <= `SWS_WDOG_RST;                             // RULE11
            s_q.st     <= ST_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign waitrequest      = (read || write) && !s_q.ack;
    assign readdata         = s_q.rdata;
    assign stopped          = (s_q.st == ST_STOP);
    assign stop_recover     = s_q.recov;
    assign watchdog_reset   = s_q.wd_rst;
    assign reset_timer_done = s_q.rc_done;
    assign irq              = |(s_q.sts & s_q.msk);
endmodule
`default_nettype wire

/* rtl/stop_wake_map.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * stop-recovery and watchdog configuration block.
 * assumes a 100 MHz clk; included by its bare name after the package.
 */
// What this block does
// RULE1: the second wake select register keeps its source code in bits 4..2 and its level in bit 6, and software cannot read them back.
// RULE2: code 000 (reset) allows only power-on reset, 001 wakes on nand of port 2 lines 0-3, 010 on nand of port 2 lines 0-7.
// RULE3: code 011 wakes on nor of port 3 lines 1-3 and code 100 on nand of the same lines.
// RULE4: code 101 wakes on nor of port 3 lines 1-3 with port 0 lines 0 and 7, code 110 on nand of that set.
// RULE5: code 111 wakes on nand of port 3 lines 1-3 with port 2 lines 0-2.
// RULE6: the level bit (reset 0) is the pin-combination level that triggers recovery.
// RULE7: with both wake select registers set up, the event of either one ends stop.
// RULE8: lines configured as outputs drop out of the combination, which is formed from the remaining inputs.
// RULE9: software writes zero to every reserved bit of the second wake select register.
// RULE10: watchdog time select 00/01/10/11 gives at least 5/10/20/80 ms.
// RULE11: watchdog mode bit 2 keeps the watchdog running in halt when 1, its reset value.
// RULE12: a rising edge on clear input a starts the watchdog timer, on clear input b the 18-clock reset timer.
// RULE13: while stopped the selected combination is watched every cycle and recovery starts on a match.
`ifndef STOP_WAKE_MAP_SVH
`define STOP_WAKE_MAP_SVH

// ********************************************************************
// register map (word index times four gives byte address)
// ********************************************************************
`define SWS_IDX_SECOND     4'hd
`define SWS_IDX_FIRST      4'he
`define SWS_IDX_WDOG       4'hf
`define SWS_IDX_STATUS     4'hc
`define SWS_IDX_MASK       4'hb

// ********************************************************************
// fields and reset values
// ********************************************************************
`define SWS_SRC_LSB        2
`define SWS_SRC_MSB        4
`define SWS_LVL_BIT        6
`define SWS_SECOND_RST     8'h00
`define SWS_FIRST_RST      8'h00
`define SWS_WDOG_RST       8'h04
`define SWS_WD_HALT_BIT    2

// ********************************************************************
// timing
// ********************************************************************
`define SWS_CLK_MHZ        100
`define SWS_WD_MS0         5
`define SWS_WD_MS1         10
`define SWS_WD_MS2         20
`define SWS_WD_MS3         80
`define SWS_WD_CYC(ms)     ((ms) * 1000 * `SWS_CLK_MHZ)
`define SWS_RST_CLOCKS     18

`endif

/* rtl/stop_wake_pkg.sv */
/*
 * types shared by the stop-recovery block and its pin combiner.
 * assumes nothing beyond a SystemVerilog tool.
 */
package stop_wake_pkg;
    // pins that may take part in a wake combination, with direction flags
    typedef struct packed {
        logic [7:0] port0;
        logic [7:0] port2;
        logic [3:1] port3;
    } wake_pins_t;

    typedef enum logic [2:0] {
        SRC_POR_ONLY = 3'b000,
        SRC_NAND_P2L = 3'b001,
        SRC_NAND_P2A = 3'b010,
        SRC_NOR_P3   = 3'b011,
        SRC_NAND_P3  = 3'b100,
        SRC_NOR_P30  = 3'b101,
        SRC_NAND_P30 = 3'b110,
        SRC_NAND_P32 = 3'b111
    } wake_src_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_HALT = 2'b10
    } run_state_t;
endpackage

/* rtl/wake_combiner.sv */
/*
 * forms the nand or nor of the selected wake pins, leaving out outputs.
 * assumes pins are synchronous to clk; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
module wake_combiner (
    // selection
    input  wire stop_wake_pkg::wake_src_t  src,
    input  wire logic                      level,
    // pins and their directions (1 = output)
    input  wire stop_wake_pkg::wake_pins_t pins,
    input  wire stop_wake_pkg::wake_pins_t is_out,
    // result
    output logic                           wake
);
    import stop_wake_pkg::*;

    logic [18:0] sel;
    logic [18:0] use_m;
    logic        any_hi;
    logic        all_hi;
    logic        comb;
    logic        is_nor;

    // choose the set of lines per source code
    always_comb begin
        sel    = 19'h0_0000;
        is_nor = 1'b0;
        case (src)
            SRC_NAND_P2L: sel = {8'h00, 8'h0f, 3'b000};          // RULE2
            SRC_NAND_P2A: sel = {8'h00, 8'hff, 3'b000};          // RULE2
            SRC_NOR_P3: begin
                sel    = {8'h00, 8'h00, 3'b111};                 // RULE3
                is_nor = 1'b1;
            end
            SRC_NAND_P3:  sel = {8'h00, 8'h00, 3'b111};          // RULE3
            SRC_NOR_P30: begin
                sel    = {8'h81, 8'h00, 3'b111};                 // RULE4
                is_nor = 1'b1;
            end
            SRC_NAND_P30: sel = {8'h81, 8'h00, 3'b111};          // RULE4
            SRC_NAND_P32: sel = {8'h00, 8'h07, 3'b111};          // RULE5
            default:      sel = 19'h0_0000;                      // RULE2
        endcase
    end

    // outputs drop out of the equation
    assign use_m  = sel & ~is_out;                                // RULE8
    assign any_hi = |(pins & use_m);
    assign all_hi = &(pins | ~use_m);
    assign comb   = is_nor ? ~any_hi : ~all_hi;
    // no live line left means nothing can wake; por only never wakes
    assign wake   = (|use_m) && (comb == level);                  // RULE6
endmodule
`default_nettype wire

/* testbench/pin_model.sv */
/* far-side port lines: intended levels and the direction of each line.
   assumes the bench changes level and dir just after a clk edge. */
`timescale 1ns/10ps
`default_nettype none
module pin_model (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // intended levels and directions (1 = output)
    input  wire stop_wake_pkg::wake_pins_t level,
    input  wire stop_wake_pkg::wake_pins_t dir,
    // to the device
    output wire stop_wake_pkg::wake_pins_t pins,
    output wire stop_wake_pkg::wake_pins_t is_out
);
    import stop_wake_pkg::*;
    wake_pins_t noise_q;
    // output lines flip every cycle, so a slip that counts them shows up
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            noise_q <= '0;
        end else begin
            noise_q <= ~noise_q;
        end
    end
    assign pins   = (level & ~dir) | (noise_q & dir);
    assign is_out = dir;
endmodule
`default_nettype wire

/* testbench/stop_wake_properties.sv */
/* checker for the stop-recovery block, bound to its top module.
   assumes one clock, rstn active low, a bus master that holds requests. */
`timescale 1ns/10ps
`default_nettype none
module stop_wake_checker #(
    parameter int RST_CLOCKS = 18
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // bus and events
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        timer_clear_input_b,
    input wire logic        stopped,
    input wire logic        stop_recover,
    input wire logic        watchdog_reset,
    input wire logic        reset_timer_done,
    input wire logic        irq
);
    // one cycle of slack, the rise may be seen an edge late
    localparam int RST_LAT = RST_CLOCKS + 1;
    localparam int RST_HI  = RST_CLOCKS + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    read_hold_a: assert property (!(read || write) |=> $stable(readdata))
        else $error("readdata changed without an access");
    rec_pulse_a: assert property (stop_recover |=> !stop_recover)
        else $error("recovery pulse longer than one cycle");
    rec_exit_a: assert property ($fell(stopped) |-> stop_recover)
        else $error("stop left without a recovery pulse");
    rec_cause_a: assert property (stop_recover |-> $past(stopped) && !stopped)
        else $error("recovery pulse outside stop");
    rst_timer_a: assert property ($rose(timer_clear_input_b) |-> ##[RST_LAT:RST_HI] reset_timer_done)
        else $error("reset timer span wrong");
    rst_pulse_a: assert property (reset_timer_done |=> !reset_timer_done)
        else $error("reset timer pulse too long");
    wdog_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog pulse too long");
    cover property (stop_recover);
    cover property (watchdog_reset);
    cover property (reset_timer_done);
    cover property (irq);
endmodule
bind stop_wake_ctrl stop_wake_checker #(.RST_CLOCKS(RST_CLOCKS)) i_stop_wake_checker (
    .clk(clk), .rstn(rstn), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .timer_clear_input_b(timer_clear_input_b),
    .stopped(stopped), .stop_recover(stop_recover), .watchdog_reset(watchdog_reset),
    .reset_timer_done(reset_timer_done), .irq(irq));
`default_nettype wire

/* testbench/testbench.sv */
/* self-checking bench: registers over the bus, wake codes, timers.
   assumes short watchdog limits 4/6/8/10 cycles and 18 reset clocks. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import stop_wake_pkg::*;
    localparam int WD [4] = '{4, 6, 8, 10};
    logic        clk = 0, rstn = 0, read = 0, write = 0, stop_req = 0, halt_req = 0;
    logic        halt_exit = 0, first_wake_in = 0, timer_clear_input_a = 0;
    logic        timer_clear_input_b = 0, waitrequest, stopped, stop_recover, irq;
    logic        watchdog_reset, reset_timer_done;
    logic [5:0]  address = '0;
    logic [31:0] writedata = '0, readdata, rd, r;
    wake_pins_t  lvl = '0, dir = '0, pins, is_out;
    integer      seed = 39, err_count = 0, n_tests = 0, rec_cnt = 0, wd_cnt = 0, n;

    always #5 clk = ~clk;
    // event counters, read by the checks at the falling edge
    always @(posedge clk) begin
        if (stop_recover === 1'b1) rec_cnt = rec_cnt + 1;
        if (watchdog_reset === 1'b1) wd_cnt = wd_cnt + 1;
    end

    stop_wake_ctrl #(.WD_CYC0(4), .WD_CYC1(6), .WD_CYC2(8), .WD_CYC3(10), .RST_CLOCKS(18))
    i_stop_wake_ctrl (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .stop_req(stop_req), .halt_req(halt_req), .halt_exit(halt_exit), .pins(pins),
        .is_out(is_out), .first_wake_in(first_wake_in),
        .timer_clear_input_a(timer_clear_input_a), .timer_clear_input_b(timer_clear_input_b),
        .stopped(stopped), .stop_recover(stop_recover), .watchdog_reset(watchdog_reset),
        .reset_timer_done(reset_timer_done), .irq(irq));
    pin_model i_pin_model (.clk(clk), .rstn(rstn), .level(lvl), .dir(dir), .pins(pins),
        .is_out(is_out));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) chk("bus answer", 0, 1);
    endtask
    task automatic wait_wd(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (watchdog_reset !== 1'b1 && k < 60);
    endtask
    function automatic logic wake_exp(input logic [2:0] c, input logic l,
                                      input wake_pins_t p, input wake_pins_t o);
        wake_pins_t sel, live;
        sel = '0;
        case (c)
            3'h1: sel.port2 = 8'h0f;
            3'h2: sel.port2 = 8'hff;
            3'h3, 3'h4: sel.port3 = 3'h7;
            3'h5, 3'h6: sel = '{port0: 8'h81, port2: 8'h00, port3: 3'h7};
            3'h7: sel = '{port0: 8'h00, port2: 8'h07, port3: 3'h7};
            default: sel = '0;
        endcase
        live = sel & ~o;
        if (live == '0) return 1'b0;
        if (c == 3'h3 || c == 3'h5) return (~|(p & live)) == l;
        return (~&(p | ~live)) == l;
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        // about twenty times the cycles the tests need
        #200_000;
        err_count++;
        test_done;
    end

    initial begin
        logic [2:0] code;
        logic       l, e;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus(0, 6'h34, 0);
        chk("second readback", 0, rd);
        bus(0, 6'h3c, 0);
        chk("watchdog mode reset", 32'h4, rd);
        bus(1, 6'h04, 32'hffff_ffff);
        bus(0, 6'h04, 0);
        chk("unmapped read", 0, rd);
        bus(1, 6'h38, 1);
        // every code at both levels, random pins with sparse outputs
        for (int i = 0; i < 48; i++) begin
            code = i[2:0];
            l = i[3];
            r = (i % 3) ? $random(seed) | $random(seed) : $random(seed) & $random(seed);
            lvl <= r[18:0];
            r = $random(seed) & $random(seed) & $random(seed);
            if (i == 9) r[6:3] = 4'hf;
            dir <= r[18:0];
            bus(1, 6'h34, {25'h0, l, 1'b0, code, 2'b00});
            bus(1, 6'h2c, {31'h0, i[0]});
            e = wake_exp(code, l, lvl, dir);
            rec_cnt = 0;
            @(posedge clk) stop_req <= 1'b1;
            @(posedge clk) stop_req <= 1'b0;
            repeat (4) @(negedge clk);
            chk("wake", {31'h0, e}, rec_cnt);
            chk("stopped", {31'h0, !e}, stopped);
            if (!e) begin
                @(posedge clk) first_wake_in <= 1'b1;
                @(posedge clk) first_wake_in <= 1'b0;
                repeat (3) @(negedge clk);
                chk("first event wake", 1, rec_cnt);
            end
            chk("irq", {31'h0, i[0]}, irq);
            bus(0, 6'h30, 0);
            chk("status", 1, rd);
            @(negedge clk);
            chk("irq cleared", 0, irq);
        end
        $display("wake trials done");
        @(posedge clk) timer_clear_input_b <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (reset_timer_done !== 1'b1 && n < 60);
        chk("reset timer span", 1, n >= 19 && n <= 21);
        $display("reset timer done");
        @(posedge clk) timer_clear_input_a <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            bus(1, 6'h3c, {29'h0000_0001, 1'b1, s[1:0]});
            wait_wd(n);
            wait_wd(n);
            chk("watchdog period", 1, n >= WD[s] && n <= WD[s] + 2);
        end
        bus(1, 6'h3c, 0);
        @(posedge clk) halt_req <= 1'b1;
        @(posedge clk) halt_req <= 1'b0;
        // a pulse launched on the edge that enters halt is counted one edge later
        repeat (2) @(negedge clk);
        wd_cnt = 0;
        repeat (40) @(negedge clk);
        chk("watchdog frozen in halt", 0, wd_cnt);
        bus(1, 6'h3c, 32'h4);
        @(negedge clk) wd_cnt = 0;
        repeat (40) @(negedge clk);
        chk("watchdog runs in halt", 1, wd_cnt > 0);
        @(posedge clk) halt_exit <= 1'b1;
        @(posedge clk) halt_exit <= 1'b0;
        $display("watchdog tests done");
        test_done;
    end
endmodule
`default_nettype wire
